// file: src/mqaf_pkg.sv
// Constants for the multi-queue active flag block: geometry, register map, defaults.
// Assumes one clock domain serves both queue ports.
// Functional notes
// - Output-valid flag updates on the same edge that loads the output register.
// - Empty status kept per queue; only the read-selected queue drives the flag.
// - After the last word, next enabled read raises the output-valid flag.
// - New read queue data and its flag appear two edges after selection.
// - Until then the old queue keeps supplying words and flag status.
// - Output-valid flag changes only on rising clock edges.
// - Writes update empty status of queues not selected for reading.
// - Flag enable drops when the read address ID field names another device; a null queue keeps it.
// - Top three read address bits matched against strap ID enable the flag.
// - Switches within one device keep the flag driven and updated.
// - Almost-full kept per queue; only the write-selected queue drives the flag.
// - Almost-full offset programmable 0 to depth, or default 8 or 128.
// - Each queue holds its own independent almost-full offset.
// - New write queue's almost-full status shows on second edge after selection.
// - Almost-full path double registered: flag falls two edges after crossing write.
// - A read clearing almost-full raises the flag two edges after the read.
// - Almost-full flag changes on rising edges; reads may change internal status.
// - Output-valid flag is active low; high means selected queue is empty.
package mqaf_pkg;
  localparam int         MQAF_NQ        = 4;    // Queues per device
  localparam int         MQAF_DW        = 18;   // Word width
  localparam int         MQAF_DEPTH     = 256;  // Words per queue
  localparam int         MQAF_AW        = 6;    // Queue address width
  localparam int         MQAF_ID_LSB    = 3;    // Device ID field [5:3]
  localparam int         MQAF_NULL_BIT  = 2;    // Null queue select
  localparam int         MQAF_AF_LO     = 8;    // Default offset, low choice
  localparam int         MQAF_AF_HI     = 128;  // Default offset, high choice
  // Register word indices, byte address is four times the index
  localparam logic [2:0] MQAF_REG_CTRL  = 3'h0;
  localparam logic [2:0] MQAF_REG_OFF0  = 3'h1;
  localparam logic [2:0] MQAF_REG_OFF3  = 3'h4;
  localparam logic [2:0] MQAF_REG_STAT  = 3'h5;
  localparam int         MQAF_CTRL_PROG = 0;    // Use programmed offsets
  localparam int         MQAF_CTRL_HI   = 1;    // Default offset is 128
  localparam int         MQAF_STAT_EMP  = 0;    // [3:0] queue empty
  localparam int         MQAF_STAT_AF   = 4;    // [7:4] queue almost full
  localparam int         MQAF_STAT_OV   = 8;
  localparam int         MQAF_STAT_PAF  = 9;
endpackage : mqaf_pkg

// file: src/mqaf_cfg_if.sv
// Carrier between register slave and flag core: offsets out, status back.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
`default_nettype none
interface mqaf_cfg_if #(parameter int OW = 9);
  import mqaf_pkg::*;
  logic                   use_prog;
  logic                   def_hi;
  logic [OW-1:0]          off [MQAF_NQ];
  logic [MQAF_NQ-1:0]     q_empty;
  logic [MQAF_NQ-1:0]     q_af;
  logic                   ov_n;
  logic                   paf_n;
  modport regs (output use_prog, def_hi, off, input q_empty, q_af, ov_n, paf_n);
  modport core (input use_prog, def_hi, off, output q_empty, q_af, ov_n, paf_n);
endinterface : mqaf_cfg_if
`default_nettype wire

// file: src/mqaf_regs.sv
// Avalon-MM slave holding control and per-queue almost-full offsets.
// Assumes a master that holds its request until waitrequest is seen low.
`timescale 1ns/1ps
`default_nettype none
module mqaf_regs import mqaf_pkg::*; #(
  parameter int OW    = 9,
  parameter int DEPTH = MQAF_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Core side
  mqaf_cfg_if.regs         cfg
);
  logic          use_prog, next_use_prog;
  logic          def_hi, next_def_hi;
  logic [OW-1:0] off [MQAF_NQ];
  logic [OW-1:0] next_off [MQAF_NQ];
  logic [31:0]   next_rdata, cur, merged;
  logic          next_wait;

  assign cfg.use_prog = use_prog;
  assign cfg.def_hi   = def_hi;
  assign cfg.off      = off;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped words read as zero
  function automatic logic [31:0] word_at(input logic [2:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == MQAF_REG_CTRL) begin
      w[MQAF_CTRL_PROG] = use_prog;
      w[MQAF_CTRL_HI]   = def_hi;
    end else if (a >= MQAF_REG_OFF0 && a <= MQAF_REG_OFF3) begin
      w[OW-1:0] = off[2'(a - MQAF_REG_OFF0)];
    end else if (a == MQAF_REG_STAT) begin
      w[MQAF_STAT_EMP +: MQAF_NQ] = cfg.q_empty;
      w[MQAF_STAT_AF +: MQAF_NQ]  = cfg.q_af;
      w[MQAF_STAT_OV]             = cfg.ov_n;
      w[MQAF_STAT_PAF]            = cfg.paf_n;
    end
    return w;
  endfunction : word_at

  ////////////////////////////////////////////////////////////////////////////
  // One wait cycle per access: reads sample at first edge, writes at the second; both answer at the second
  always_comb begin
    next_wait     = ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
    next_rdata    = avs_readdata_out;
    next_use_prog = use_prog;
    next_def_hi   = def_hi;
    next_off      = off;
    cur           = word_at(avs_address_in);
    for (int b = 0; b < 4; b++) begin
      merged[8*b +: 8] = avs_byteenable_in[b] ? avs_writedata_in[8*b +: 8] : cur[8*b +: 8];
    end
    if (avs_read_in && avs_waitrequest_out) begin
      next_rdata = cur;
    end
    if (avs_write_in && !avs_waitrequest_out) begin
      if (avs_address_in == MQAF_REG_CTRL) begin
        next_use_prog = merged[MQAF_CTRL_PROG];
        next_def_hi   = merged[MQAF_CTRL_HI];
      end else if (avs_address_in >= MQAF_REG_OFF0 && avs_address_in <= MQAF_REG_OFF3) begin
        // Offset beyond the queue depth is clamped to the depth
        next_off[2'(avs_address_in - MQAF_REG_OFF0)] =
          (merged[OW-1:0] > OW'(DEPTH)) ? OW'(DEPTH) : merged[OW-1:0];
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
      use_prog            <= 1'b0;
      def_hi              <= 1'b0;
      for (int i = 0; i < MQAF_NQ; i++) begin
        off[i] <= OW'(MQAF_AF_LO);
      end
    end else begin
      avs_waitrequest_out <= next_wait;
      avs_readdata_out    <= next_rdata;
      use_prog            <= next_use_prog;
      def_hi              <= next_def_hi;
      off                 <= next_off;
    end
  end
endmodule : mqaf_regs
`default_nettype wire

// file: src/mqaf_flags.sv
// Four-queue store with active-queue output-valid and almost-full flags.
// Assumes both queue ports run on the system clock and straps are static.
//
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module mqaf_flags import mqaf_pkg::*; #(
  parameter int DW    = MQAF_DW,
  parameter int DEPTH = MQAF_DEPTH
) (
  // Clock and reset
  input  wire logic               clk_sys_in,
  input  wire logic               sys_rst_in,
  // Write port
  input  wire logic [MQAF_AW-1:0] write_queue_address_in,
  input  wire logic               write_address_enable_in,
  input  wire logic               write_enable_n_in,
  input  wire logic [DW-1:0]      write_data_in,
  // Read port
  input  wire logic [MQAF_AW-1:0] read_queue_address_in,
  input  wire logic               read_address_enable_in,
  input  wire logic               read_enable_n_in,
  // Device ID straps
  input  wire logic               device_id_strap_0_in,
  input  wire logic               device_id_strap_1_in,
  input  wire logic               device_id_strap_2_in,
  // Data and flags
  output logic      [DW-1:0]      read_data_out,
  output logic                    output_valid_flag_n_out,
  output logic                    output_valid_flag_oe_out,
  output logic                    almost_full_flag_n_out,
  // Avalon-MM slave
  input  wire logic [2:0]         avs_address_in,
  input  wire logic               avs_read_in,
  input  wire logic               avs_write_in,
  input  wire logic [31:0]        avs_writedata_in,
  input  wire logic [3:0]         avs_byteenable_in,
  output logic      [31:0]        avs_readdata_out,
  output logic                    avs_waitrequest_out
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  mqaf_cfg_if #(.OW(CW)) cfg ();

  mqaf_regs #(.OW(CW), .DEPTH(DEPTH)) u_regs (
    .clk_sys_in          (clk_sys_in),
    .sys_rst_in          (sys_rst_in),
    .avs_address_in      (avs_address_in),
    .avs_read_in         (avs_read_in),
    .avs_write_in        (avs_write_in),
    .avs_writedata_in    (avs_writedata_in),
    .avs_byteenable_in   (avs_byteenable_in),
    .avs_readdata_out    (avs_readdata_out),
    .avs_waitrequest_out (avs_waitrequest_out),
    .cfg                 (cfg)
  );

  // Storage: one flat array, queue number as the top index bits
  logic [DW-1:0]      mem [MQAF_NQ*DEPTH];
  logic [CW-1:0]      cnt [MQAF_NQ];
  logic [CW-1:0]      next_cnt [MQAF_NQ];
  logic [PW-1:0]      wptr [MQAF_NQ];
  logic [PW-1:0]      next_wptr [MQAF_NQ];
  logic [PW-1:0]      rptr [MQAF_NQ];
  logic [PW-1:0]      next_rptr [MQAF_NQ];
  logic [MQAF_NQ-1:0] af_vec;
  logic [2:0]         dev_id;

  // Read-side state
  logic               rp1_vld, next_rp1_vld, rp2_vld, next_rp2_vld;
  logic [MQAF_AW-1:0] rp1_adr, next_rp1_adr, rp2_adr, next_rp2_adr;
  logic [1:0]         rq, next_rq, tq;
  logic               r_ours, next_r_ours, tours;
  logic               next_ov_n, next_oe, need, pop;
  logic [DW-1:0]      next_dout, head_word;

  // Write-side state
  logic               wp1_vld, next_wp1_vld;
  logic [MQAF_AW-1:0] wp1_adr, next_wp1_adr;
  logic [1:0]         wq, next_wq;
  logic               w_ours, next_w_ours, wr_do;
  logic               af1, next_af1, next_paf_n;

  assign dev_id = {device_id_strap_2_in, device_id_strap_1_in, device_id_strap_0_in};

  // A read address names a local, non-null queue
  function automatic logic local_q(input logic [MQAF_AW-1:0] a, input logic [2:0] id);
    return (a[MQAF_AW-1:MQAF_ID_LSB] == id) && !a[MQAF_NULL_BIT];
  endfunction : local_q

  ////////////////////////////////////////////////////////////////////////////
  // Per-queue occupancy, pointers and almost-full status
  for (genvar i = 0; i < MQAF_NQ; i++) begin : g_q
    logic          inc, dec;
    logic [CW-1:0] off_eff;
    always_comb begin
      inc          = wr_do && (wq == 2'(i));
      dec          = pop && (tq == 2'(i));
      next_cnt[i]  = cnt[i];
      next_wptr[i] = inc ? wptr[i] + PW'(1) : wptr[i];
      next_rptr[i] = dec ? rptr[i] + PW'(1) : rptr[i];
      if (inc && !dec) begin
        next_cnt[i] = cnt[i] + CW'(1);
      end else if (dec && !inc) begin
        next_cnt[i] = cnt[i] - CW'(1);
      end
    end
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        cnt[i]  <= '0;
        wptr[i] <= '0;
        rptr[i] <= '0;
      end else begin
        cnt[i]  <= next_cnt[i];
        wptr[i] <= next_wptr[i];
        rptr[i] <= next_rptr[i];
      end
    end
    // Programmed offset, or one of the two defaults
    assign off_eff = cfg.use_prog ? cfg.off[i]
                   : (cfg.def_hi ? CW'(MQAF_AF_HI) : CW'(MQAF_AF_LO));
    // Free space at or below the offset counts as almost full
    assign af_vec[i]      = cnt[i] >= (CW'(DEPTH) - off_eff);
    assign cfg.q_empty[i] = (cnt[i] == '0);
    assign cfg.q_af[i]    = af_vec[i];
  end

  assign cfg.ov_n  = output_valid_flag_n_out;
  assign cfg.paf_n = almost_full_flag_n_out;

  ////////////////////////////////////////////////////////////////////////////
  // Memory write; no reset on the array to keep it a plain RAM
  always_ff @(posedge clk_sys_in) begin
    if (wr_do) begin
      mem[{wq, wptr[wq]}] <= write_data_in;
    end
  end

  // Asynchronous head read keeps first-word fall-through to one edge
  assign head_word = mem[{tq, rptr[tq]}];

  ////////////////////////////////////////////////////////////////////////////
  // Read port: two-stage selection, output register and flag
  always_comb begin
    next_rp1_vld = read_address_enable_in;
    next_rp1_adr = read_address_enable_in ? read_queue_address_in : rp1_adr;
    next_rp2_vld = rp1_vld;
    next_rp2_adr = rp1_adr;
    // Selection lands on its second edge; before that the old queue serves
    tq    = rp2_vld ? rp2_adr[1:0] : rq;
    tours = rp2_vld ? local_q(rp2_adr, dev_id) : r_ours;
    // Load on a switch, on an empty output register, or on an enabled read
    need  = rp2_vld || output_valid_flag_n_out || !read_enable_n_in;
    pop   = need && tours && (cnt[tq] != '0);
    next_ov_n   = pop ? 1'b0 : (need ? 1'b1 : output_valid_flag_n_out);
    next_dout   = pop ? head_word : read_data_out;
    next_rq     = tq;
    next_r_ours = tours;
    // Drive the shared flag only when the ID field names this device
    next_oe     = rp2_vld ? (rp2_adr[MQAF_AW-1:MQAF_ID_LSB] == dev_id)
                          : output_valid_flag_oe_out;
  end

  // Read-side registers; flag moves only here
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rp1_vld                  <= 1'b0;
      rp1_adr                  <= '0;
      rp2_vld                  <= 1'b0;
      rp2_adr                  <= '0;
      rq                       <= 2'h0;
      r_ours                   <= 1'b0;
      read_data_out            <= '0;
      output_valid_flag_n_out  <= 1'b1;
      output_valid_flag_oe_out <= 1'b0;
    end else begin
      rp1_vld                  <= next_rp1_vld;
      rp1_adr                  <= next_rp1_adr;
      rp2_vld                  <= next_rp2_vld;
      rp2_adr                  <= next_rp2_adr;
      rq                       <= next_rq;
      r_ours                   <= next_r_ours;
      read_data_out            <= next_dout;
      output_valid_flag_n_out  <= next_ov_n;
      output_valid_flag_oe_out <= next_oe;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write port: queue active one edge after selection, flag one edge later
  always_comb begin
    next_wp1_vld = write_address_enable_in;
    next_wp1_adr = write_address_enable_in ? write_queue_address_in : wp1_adr;
    next_wq      = wp1_vld ? wp1_adr[1:0] : wq;
    next_w_ours  = wp1_vld ? (wp1_adr[MQAF_AW-1:MQAF_ID_LSB] == dev_id) : w_ours;
    // Writes to a full queue are dropped
    wr_do        = !write_enable_n_in && w_ours && (cnt[wq] != CW'(DEPTH));
    // First stage already looks at the queue that becomes active
    next_af1     = next_w_ours && af_vec[next_wq];
    next_paf_n   = !af1;
  end

  // Write-side registers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wp1_vld                <= 1'b0;
      wp1_adr                <= '0;
      wq                     <= 2'h0;
      w_ours                 <= 1'b0;
      af1                    <= 1'b0;
      almost_full_flag_n_out <= 1'b1;
    end else begin
      wp1_vld                <= next_wp1_vld;
      wp1_adr                <= next_wp1_adr;
      wq                     <= next_wq;
      w_ours                 <= next_w_ours;
      af1                    <= next_af1;
      almost_full_flag_n_out <= next_paf_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  a_ov_load_valid: assert property (pop |=> !output_valid_flag_n_out)
    else $error("flag not valid after load");
  a_ov_word_match: assert property (pop |=> read_data_out == $past(head_word))
    else $error("output word not from queue head");
  a_ov_foreign_q: assert property ((rp2_vld && !local_q(rp2_adr, dev_id)) |=> output_valid_flag_n_out)
    else $error("flag valid for unselected queue");
  a_ov_last_word: assert property ((!output_valid_flag_n_out && !read_enable_n_in && !rp2_vld
      && (!r_ours || cnt[rq] == '0)) |=> output_valid_flag_n_out)
    else $error("flag low after last word read");
  a_sel_two_edges: assert property (read_address_enable_in ##1 !read_address_enable_in ##1 1
      |=> rq == $past(read_queue_address_in[1:0], 3))
    else $error("read queue not switched on second edge");
  a_sel_old_serves: assert property ((read_address_enable_in && !rp1_vld && !rp2_vld)
      |=> (rq == $past(rq)) [*2])
    else $error("queue switched too early");
  a_oe_id_match: assert property (read_address_enable_in ##1 !read_address_enable_in ##1 1
      |=> output_valid_flag_oe_out == ($past(read_queue_address_in[5:3], 3) == dev_id))
    else $error("flag enable does not follow ID match");
  a_oe_release: assert property ((read_address_enable_in && read_queue_address_in[5:3] != dev_id)
      ##1 !read_address_enable_in ##1 1 |=> !output_valid_flag_oe_out)
    else $error("flag still driven for foreign device");
  // A foreign selection still in the pipeline may release the line legally
  a_oe_kept_local: assert property ((read_address_enable_in && read_queue_address_in[5:3] == dev_id
      && !rp1_vld && !rp2_vld && output_valid_flag_oe_out) |=> output_valid_flag_oe_out [*3])
    else $error("flag released on local switch");
  // Outside a write switch the flag shows the active queue status two edges late
  a_af_two_edges: assert property (!$past(wp1_vld, 2) |-> almost_full_flag_n_out == !$past(w_ours && af_vec[wq], 2))
    else $error("almost-full latency not two edges");
  a_wsel_active: assert property (write_address_enable_in |=> ##1
      wq == $past(write_queue_address_in[1:0], 2))
    else $error("write queue not active one edge after selection");
  a_write_counts: assert property ((wr_do && !(pop && tq == wq))
      |=> cnt[$past(wq)] == $past(cnt[wq]) + CW'(1))
    else $error("write did not raise queue count");

  c_switch_valid: cover property (rp2_vld ##1 !output_valid_flag_n_out);
  c_af_assert:    cover property ($fell(almost_full_flag_n_out));
  c_oe_release:   cover property ($fell(output_valid_flag_oe_out));
  c_last_read:    cover property ($rose(output_valid_flag_n_out));
endmodule : mqaf_flags
`default_nettype wire

// file: dv/mqaf_ctl_model.sv
// Controller model: drives the write and read queue ports of the flag block.
// Assumes a single device on the shared lines and a bench that calls its tasks.
`timescale 1ns/1ps
`default_nettype none
module mqaf_ctl_model import mqaf_pkg::*; (
  // Clock
  input  wire logic               clk_sys_in,
  // Write port
  output logic      [MQAF_AW-1:0] wq_addr_out,
  output logic                    wq_sel_out,
  output logic                    wen_n_out,
  output logic      [MQAF_DW-1:0] wdata_out,
  // Read port
  output logic      [MQAF_AW-1:0] rq_addr_out,
  output logic                    rq_sel_out,
  output logic                    ren_n_out
);
  ////////////////////////////////////////////////////////////
  // Idle levels from time zero
  initial begin
    wq_addr_out = '0;
    wq_sel_out  = 1'b0;
    wen_n_out   = 1'b1;
    wdata_out   = '0;
    rq_addr_out = '0;
    rq_sel_out  = 1'b0;
    ren_n_out   = 1'b1;
  end
  // Queue select: address and enable seen at exactly one edge
  task automatic sel(input logic rd, input logic [MQAF_AW-1:0] a);
    @(posedge clk_sys_in);
    if (rd) begin
      rq_addr_out <= a;
      rq_sel_out  <= 1'b1;
    end else begin
      wq_addr_out <= a;
      wq_sel_out  <= 1'b1;
    end
    @(posedge clk_sys_in);
    rq_sel_out <= 1'b0;
    wq_sel_out <= 1'b0;
  endtask : sel
  // One word per edge; back to back calls stream words
  task automatic wr(input logic [MQAF_DW-1:0] d);
    @(posedge clk_sys_in);
    wen_n_out <= 1'b0;
    wdata_out <= d;
  endtask : wr
  // Release scrambles data so a stale word is never reused
  task automatic wr_end();
    @(posedge clk_sys_in);
    wen_n_out <= 1'b1;
    wdata_out <= ~wdata_out;
  endtask : wr_end
  // Single enabled read, taken at the edge where the task returns
  task automatic rd();
    @(posedge clk_sys_in);
    ren_n_out <= 1'b0;
    @(posedge clk_sys_in);
    ren_n_out <= 1'b1;
  endtask : rd
endmodule : mqaf_ctl_model
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the flag block with a controller model.
// Assumes the flag block and its package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb import mqaf_pkg::*;;
  localparam int DEPTH = 128;
  logic              clk_sys_in = 1'b0;
  logic              sys_rst_in = 1'b1;
  logic [2:0]        id;
  logic [2:0]        avs_addr   = '0;
  logic              avs_rd     = 1'b0;
  logic              avs_wr     = 1'b0;
  logic [31:0]       avs_wdata  = '0;
  logic [31:0]       avs_rdata;
  logic              avs_wait;
  logic [MQAF_AW-1:0] wq_addr, rq_addr;
  logic              wq_sel, rq_sel, wen_n, ren_n, ov_n, ov_oe, paf_n;
  logic [MQAF_DW-1:0] wdata, rdata;
  logic [MQAF_DW-1:0] mem [4][$];
  logic [31:0]       seed = 32'h46;
  int                k [4];
  int                bad_count = 0;
  int                tests_run = 0;
  always #5 clk_sys_in = ~clk_sys_in;
  mqaf_ctl_model m (.clk_sys_in(clk_sys_in), .wq_addr_out(wq_addr), .wq_sel_out(wq_sel), .wen_n_out(wen_n),
    .wdata_out(wdata), .rq_addr_out(rq_addr), .rq_sel_out(rq_sel), .ren_n_out(ren_n));
  mqaf_flags #(.DEPTH(DEPTH)) mqaf_flags_i (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .write_queue_address_in(wq_addr), .write_address_enable_in(wq_sel), .write_enable_n_in(wen_n),
    .write_data_in(wdata), .read_queue_address_in(rq_addr), .read_address_enable_in(rq_sel),
    .read_enable_n_in(ren_n), .device_id_strap_0_in(id[0]), .device_id_strap_1_in(id[1]),
    .device_id_strap_2_in(id[2]), .read_data_out(rdata), .output_valid_flag_n_out(ov_n),
    .output_valid_flag_oe_out(ov_oe), .almost_full_flag_n_out(paf_n), .avs_address_in(avs_addr),
    .avs_read_in(avs_rd), .avs_write_in(avs_wr), .avs_writedata_in(avs_wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(avs_rdata), .avs_waitrequest_out(avs_wait));
  ////////////////////////////////////////////////////////////
  // Fixed-seed xorshift keeps every run identical
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Local queue address with the strapped ID on top
  function automatic logic [5:0] mk(input int q);
    return {id, 1'b0, 2'(q)};
  endfunction : mk
  // Almost full once n words reach depth minus offset, offset = depth - kq
  function automatic logic exp_af(input int n, input int kq);
    return (n >= kq) ? 1'b0 : 1'b1;
  endfunction : exp_af
  // Settle after n edges before looking at outputs
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask : tick
  task automatic cmp_flag(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : cmp_flag
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: word %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  // Avalon access: request held until waitrequest is sampled low
  task automatic avs(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    avs_addr  <= a;
    avs_wr    <= w;
    avs_rd    <= !w;
    avs_wdata <= d;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (avs_wait !== 1'b0 && n < 50);
    q = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    if (n >= 50) begin
      bad_count++;
      $display("mismatch at %0t: bus timeout", $time);
      tally_and_finish();
    end
  endtask : avs
  task automatic tally_and_finish();
    $display("counts: %0d compares, %0d mismatches", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////
  // Watchdog: whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    bad_count++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    int n;
    r = rnd();
    id = r[2:0];
    repeat (20) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    tick(0);
    cmp_flag(ov_n, 1'b1);
    cmp_flag(ov_oe, 1'b0);
    cmp_flag(paf_n, 1'b1);
    avs(1'b0, 3'h7, '0, r);
    cmp_word(r, '0);
    for (int q = 0; q < 4; q++) begin
      avs(1'b0, 3'(MQAF_REG_OFF0 + q), '0, r);
      cmp_word(r, 32'(MQAF_AF_LO));
    end
    $display("test reset done");
    // Programmed offsets put each queue 1 to 4 words from almost full
    avs(1'b1, MQAF_REG_CTRL, 32'h1, r);
    for (int q = 0; q < 4; q++) begin
      r = rnd();
      k[q] = 1 + int'(r[1:0]);
      avs(1'b1, 3'(MQAF_REG_OFF0 + q), 32'(DEPTH - k[q]), r);
      avs(1'b0, 3'(MQAF_REG_OFF0 + q), '0, r);
      cmp_word(r, 32'(DEPTH - k[q]));
    end
    $display("test offsets done");
    // Fill: queue 3 stops one word short of its boundary
    for (int q = 0; q < 4; q++) begin
      n = (q == 3) ? k[q] - 1 : k[q];
      m.sel(1'b0, mk(q));
      for (int i = 0; i < n; i++) begin
        r = rnd();
        mem[q].push_back(r[MQAF_DW-1:0]);
        m.wr(r[MQAF_DW-1:0]);
      end
      m.wr_end();
      tick(1);
      cmp_flag(paf_n, 1'b1);
      tick(1);
      cmp_flag(paf_n, exp_af(n, k[q]));
    end
    avs(1'b0, MQAF_REG_STAT, '0, r);
    cmp_word(r, {22'h0, 2'b11, 4'b0111, (k[3] == 1) ? 4'b1000 : 4'b0000});
    m.sel(1'b0, mk(1));
    tick(1);
    cmp_flag(paf_n, 1'b1);
    tick(1);
    cmp_flag(paf_n, 1'b0);
    $display("test almost full done");
    // Read select: two edges of latency, old queue serves meanwhile
    m.sel(1'b1, mk(0));
    tick(1);
    cmp_flag(ov_oe, 1'b0);
    tick(1);
    cmp_flag(ov_n, 1'b0);
    cmp_flag(ov_oe, 1'b1);
    cmp_word(32'(rdata), 32'(mem[0][0]));
    m.sel(1'b1, mk(1));
    tick(1);
    cmp_word(32'(rdata), 32'(mem[0][0]));
    cmp_flag(ov_oe, 1'b1);
    tick(1);
    cmp_word(32'(rdata), 32'(mem[1][0]));
    // That load cleared almost full; the flag must rise exactly two edges later
    cmp_flag(paf_n, 1'b0);
    tick(1);
    cmp_flag(paf_n, 1'b0);
    tick(1);
    cmp_flag(paf_n, 1'b1);
    for (int i = 1; i < k[1]; i++) begin
      m.rd();
      tick(0);
      cmp_word(32'(rdata), 32'(mem[1][i]));
      cmp_flag(ov_n, 1'b0);
    end
    m.rd();
    tick(0);
    cmp_flag(ov_n, 1'b1);
    cmp_word(32'(rdata), 32'(mem[1][k[1]-1]));
    tick(2);
    cmp_flag(paf_n, 1'b1);
    $display("test read done");
    // Null queue keeps the line driven; a foreign ID releases it
    m.sel(1'b1, {id, 1'b1, 2'b00});
    tick(2);
    cmp_flag(ov_oe, 1'b1);
    cmp_flag(ov_n, 1'b1);
    m.sel(1'b1, {id ^ 3'h1, 3'b000});
    tick(1);
    cmp_flag(ov_oe, 1'b1);
    tick(1);
    cmp_flag(ov_oe, 1'b0);
    $display("test expansion done");
    // Default offsets on the empty active write queue: 128 is almost full, 8 is not
    avs(1'b1, MQAF_REG_CTRL, 32'h2, r);
    tick(2);
    cmp_flag(paf_n, exp_af(0, DEPTH - MQAF_AF_HI));
    avs(1'b1, MQAF_REG_CTRL, 32'h0, r);
    tick(2);
    cmp_flag(paf_n, exp_af(0, DEPTH - MQAF_AF_LO));
    $display("test defaults done");
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
